// ==== verilog/fsr_pkg.sv ====
// Constants and types of the flash status register block
package fsr_pkg;
	// Serial opcode that opens a status read
	localparam logic [7:0] FSR_OP_STATUS_READ = 8'hd7;
	// Legacy density code; the value is arbitrary
	localparam logic [3:0] FSR_DENSITY_CODE = 4'h3;
	// Bit positions inside the status bytes
	localparam int FSR_B1_READY = 7;
	localparam int FSR_B1_COMPARE = 6;
	localparam int FSR_B1_DENSITY_LO = 2;
	localparam int FSR_B1_PROTECT = 1;
	localparam int FSR_B1_PAGE_SIZE = 0;
	localparam int FSR_B2_READY = 7;
	localparam int FSR_B2_ERROR = 5;
	localparam int FSR_B2_LOCKDOWN = 3;
	localparam int FSR_B2_SUSPEND_BUF2 = 2;
	localparam int FSR_B2_SUSPEND_BUF1 = 1;
	localparam int FSR_B2_ERASE_SUSPEND = 0;
	// Values after reset, and the count of the last bit of a byte
	localparam logic [2:0] FSR_RST_COUNT = 3'h0;
	localparam logic [7:0] FSR_RST_BYTE = 8'h00;
	localparam logic [2:0] FSR_LAST_BIT = 3'h7;
	// Serial link state, Gray coded along idle, opcode, status
	typedef enum logic [1:0] {
		FSR_IDLE = 2'b00,
		FSR_OPCODE = 2'b01,
		FSR_STATUS = 2'b11,
		FSR_IGNORE = 2'b10
	} fsr_state_t;
endpackage

// ==== verilog/fsr_status.sv ====
// Two-byte read-only status register of a serial flash, read over the serial link
//
// Summary of operation
// - Status byte two bit 7 is low while busy, high when ready.
// - Byte two bits 6 and 4 always read zero.
// - Error flag reads 1 when the last erase or program failed, else 0.
// - Error flag stays clear when an erase or program aborts.
// - Error flag refreshed at the end of every erase and program.
// - Byte two bit 3 is 1 while sector lockdown is still usable.
// - Bit 2 shows buffer-two program suspend; buffer-two writes then ignored.
// - Bit 1 shows buffer-one program suspend; buffer-one writes then ignored.
// - Bit 0 is 1 while any erase is suspended.
// - Compare flag holds latest compare result, 1 on any mismatch.
// - Byte one carries a fixed four-bit legacy density code.
// - Protection flag shows sector protection enabled by either method.
// - Page size flag reports 256-byte or 264-byte pages.
// - All status bits are read-only; host data is never stored.
// - After opcode D7h, status bytes one and two alternate while selected.
// - Status snapshot taken per byte; ready valid in both bytes.
// - Byte one: ready, compare, density 5:2, protect, page size.
// - Deselect at any bit ends the read and releases the output.
`timescale 1ns/100ps
`default_nettype none
module fsr_status (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic busy,
	input wire logic op_done,
	input wire logic op_failed,
	input wire logic op_abort,
	input wire logic cmp_done,
	input wire logic cmp_mismatch,
	input wire logic protect_enabled,
	input wire logic page_size_256,
	input wire logic lockdown_command_enabled_flag,
	input wire logic program_suspended_buffer_two,
	input wire logic program_suspended_buffer_one,
	input wire logic erase_suspended_flag,
	output logic buf1_write_block,
	output logic buf2_write_block
);
	import fsr_pkg::*;

	// ************************************************************
	// State of the block
	// ************************************************************
	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic sck_meta;
		logic sck_sync;
		logic sck_prev;
		logic si_meta;
		logic si_sync;
		fsr_state_t link;
		logic [2:0] count;
		logic [7:0] opcode;
		logic [7:0] shift;
		logic byte_sel;
		logic so;
		logic so_oe;
		logic error_flag;
		logic compare_flag;
		logic buf1_block;
		logic buf2_block;
	} fsr_regs_t;

	fsr_regs_t r;
	fsr_regs_t next_r;
	logic sck_rise;
	logic sck_fall;
	logic [7:0] status_byte_one;
	logic [7:0] status_byte_two;
	logic [7:0] load_byte;

	// Edges are found on synchronised copies only
	assign sck_rise = r.sck_sync & ~r.sck_prev;
	assign sck_fall = ~r.sck_sync & r.sck_prev;

	// Live status bytes, sampled into the shifter at each byte start
	always_comb begin
		status_byte_one = 8'h00;
		status_byte_one[FSR_B1_READY] = ~busy;
		status_byte_one[FSR_B1_COMPARE] = r.compare_flag;
		status_byte_one[FSR_B1_DENSITY_LO +: 4] = FSR_DENSITY_CODE;
		status_byte_one[FSR_B1_PROTECT] = protect_enabled;
		status_byte_one[FSR_B1_PAGE_SIZE] = page_size_256;
		status_byte_two = 8'h00;
		status_byte_two[FSR_B2_READY] = ~busy;
		status_byte_two[FSR_B2_ERROR] = r.error_flag;
		status_byte_two[FSR_B2_LOCKDOWN] = lockdown_command_enabled_flag;
		status_byte_two[FSR_B2_SUSPEND_BUF2] = program_suspended_buffer_two;
		status_byte_two[FSR_B2_SUSPEND_BUF1] = program_suspended_buffer_one;
		status_byte_two[FSR_B2_ERASE_SUSPEND] = erase_suspended_flag;
		load_byte = r.byte_sel ? status_byte_two : status_byte_one;
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		next_r = r;
		// Two flops on each serial pin (cs_n, sck, si) before any logic looks at it
		next_r.cs_meta = cs_n;
		next_r.cs_sync = r.cs_meta;
		next_r.sck_meta = sck;
		next_r.sck_sync = r.sck_meta;
		next_r.sck_prev = r.sck_sync;
		next_r.si_meta = si;
		next_r.si_sync = r.si_meta;
		// Abort leaves the flag clear; a finished operation overwrites it
		if (op_abort) begin
			next_r.error_flag = 1'b0;
		end else if (op_done) begin
			next_r.error_flag = op_failed;
		end
		if (cmp_done) begin
			next_r.compare_flag = cmp_mismatch;
		end
		// Buffer write lockout follows the suspend flags
		next_r.buf1_block = program_suspended_buffer_one;
		next_r.buf2_block = program_suspended_buffer_two;
		if (r.cs_sync) begin
			// Deselect ends everything at once, even mid byte
			next_r.link = FSR_IDLE;
			next_r.so_oe = 1'b0;
			next_r.so = 1'b0;
			next_r.count = FSR_RST_COUNT;
		end else begin
			case (r.link)
				FSR_IDLE: begin
					next_r.link = FSR_OPCODE;
					next_r.count = FSR_RST_COUNT;
					next_r.byte_sel = 1'b0;
				end
				FSR_OPCODE: begin
					// Opcode only steers the link; only the opcode bits are kept, nothing else from the host
					if (sck_rise) begin
						next_r.opcode = {r.opcode[6:0], r.si_sync};
						next_r.count = r.count + 3'h1;
						if (r.count == FSR_LAST_BIT) begin
							if ({r.opcode[6:0], r.si_sync} == FSR_OP_STATUS_READ) begin
								next_r.link = FSR_STATUS;
							end else begin
								next_r.link = FSR_IGNORE;
							end
						end
					end
				end
				FSR_STATUS: begin
					// Output changes on the falling edge, mode 0 and 3 alike
					if (sck_fall) begin
						next_r.so_oe = 1'b1;
						next_r.count = r.count + 3'h1;
						if (r.count == FSR_RST_COUNT) begin
							next_r.so = load_byte[7];
							next_r.shift = {load_byte[6:0], 1'b0};
						end else begin
							next_r.so = r.shift[7];
							next_r.shift = {r.shift[6:0], 1'b0};
						end
						if (r.count == FSR_LAST_BIT) begin
							next_r.byte_sel = ~r.byte_sel;
						end
					end
				end
				FSR_IGNORE: begin
					next_r.link = FSR_IGNORE;
				end
				default: begin
					next_r.link = FSR_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			r <= '0;
			r.cs_meta <= 1'b1;
			r.cs_sync <= 1'b1;
			r.link <= FSR_IDLE;
			r.opcode <= FSR_RST_BYTE;
			r.shift <= FSR_RST_BYTE;
		end else begin
			r <= next_r;
		end
	end

	assign so = r.so;
	assign so_oe = r.so_oe;
	assign buf1_write_block = r.buf1_block;
	assign buf2_write_block = r.buf2_block;

	// ************************************************************
	// Checks
	// ************************************************************
	release_on_cs_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		r.cs_sync |=> !so_oe && r.link == FSR_IDLE)
		else $error("output still driven after deselect");
	// After a byte load bit 7 is on so, so byte bit n sits at shift[n+1]
	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.link == FSR_STATUS && !r.cs_sync && sck_fall && r.count == 3'h0 && r.byte_sel)
		|=> !r.shift[7] && !r.shift[5])
		else $error("reserved status bits not zero");
	error_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(op_done && !op_abort) |=> r.error_flag == $past(op_failed))
		else $error("error flag not refreshed on completion");
	abort_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		op_abort |=> !r.error_flag)
		else $error("error flag set by an aborted operation");
	error_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!op_done && !op_abort) |=> r.error_flag == $past(r.error_flag))
		else $error("error flag changed without an operation end");
	compare_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		cmp_done |=> r.compare_flag == $past(cmp_mismatch) ##1 ($past(cmp_done) || $stable(r.compare_flag)))
		else $error("compare flag not holding latest result");
	ready_bit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.link == FSR_STATUS && !r.cs_sync && sck_fall && r.count == 3'h0) |=> so == !$past(busy))
		else $error("ready bit does not reflect busy");
	opcode_enter_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.link == FSR_OPCODE && !r.cs_sync && sck_rise && r.count == 3'h7
		&& {r.opcode[6:0], r.si_sync} == FSR_OP_STATUS_READ) |=> r.link == FSR_STATUS && !r.byte_sel)
		else $error("status read not entered after opcode");
	byte_alternate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(r.link == FSR_STATUS && !r.cs_sync && sck_fall && r.count == 3'h7) |=> r.byte_sel != $past(r.byte_sel))
		else $error("status bytes do not alternate");
	buffer_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		program_suspended_buffer_one |=> buf1_write_block)
		else $error("buffer one writes not blocked");
	buffer_two_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		program_suspended_buffer_two |=> buf2_write_block)
		else $error("buffer two writes not blocked");
endmodule
`default_nettype wire

// ==== testbench/fsr_host.sv ====
// Serial host model that reads the flash status register
`timescale 1ns/100ps
`default_nettype none
module fsr_host (
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	// Clock stands low and select stays high between frames
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// One select: opcode MSB first, then nbits taken late in each low-high period for margin
	task automatic xfer(input logic [7:0] op, input int nbits, output logic [31:0] got, output logic [31:0] goe);
		got = '0;
		goe = '0;
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			si = op[i];
			#100 sck = 1'b1;
			#100 sck = 1'b0;
		end
		for (int i = 0; i < nbits; i++) begin
			si = ~si; // Data after the opcode has no meaning
			#100 sck = 1'b1;
			#100 got = {got[30:0], so_oe ? so : ~so}; // A released line shows no stale value
			goe = {goe[30:0], so_oe};
			sck = 1'b0;
		end
		#100 cs_n = 1'b1;
		si = ~si; // A released line does not keep its last value
		#200;
	endtask
endmodule
`default_nettype wire

// ==== testbench/fsr_status_tb_top.sv ====
// Self-checking testbench of the flash status register block
`timescale 1ns/100ps
`default_nettype none
module fsr_status_tb_top;
	import fsr_pkg::*;
	logic sys_clk, nrst, cs_n, sck, si, so, so_oe, blk1, blk2;
	logic [6:0] lv; // busy, protect, page, lockdown, suspend 2, suspend 1, erase suspend
	logic [4:0] pv; // done, failed, abort, compare done, mismatch
	logic [31:0] r, got, goe;
	int seed;
	logic [7:0] e1, e2, op;
	logic err_m, cmp_m;
	int miscompares, tests_run, nb;
	fsr_status DUT (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
		.busy(lv[6]), .op_done(pv[4]), .op_failed(pv[3]), .op_abort(pv[2]), .cmp_done(pv[1]),
		.cmp_mismatch(pv[0]), .protect_enabled(lv[5]), .page_size_256(lv[4]),
		.lockdown_command_enabled_flag(lv[3]), .program_suspended_buffer_two(lv[2]),
		.program_suspended_buffer_one(lv[1]), .erase_suspended_flag(lv[0]),
		.buf1_write_block(blk1), .buf2_write_block(blk2));
	fsr_host host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Abort wins over completion; the model mirrors the error and compare flags
	task automatic pulse(input logic [4:0] p);
		@(posedge sys_clk) #1 pv = p;
		@(posedge sys_clk) #1 pv = {1'b0, p[3], 2'b00, p[0]};
		if (p[2]) err_m = 1'b0;
		else if (p[4]) err_m = p[3];
		if (p[1]) cmp_m = p[0];
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'h9ebc;
		nrst = 1'b0;
		lv = '0;
		pv = '0;
		{err_m, cmp_m, miscompares, tests_run} = '0;
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (6) @(posedge sys_clk);
		for (int n = 0; n < 30; n++) begin
			r = $random(seed);
			@(posedge sys_clk) #1 lv = r[6:0];
			pulse(r[11:7]);
			repeat (3) @(posedge sys_clk);
			#1 chk("write blocks", {lv[2], lv[1]}, {blk2, blk1});
			e1 = {~lv[6], cmp_m, FSR_DENSITY_CODE, lv[5], lv[4]};
			e2 = {~lv[6], 1'b0, err_m, 1'b0, lv[3:0]};
			op = (n % 3 == 1) ? (r[31:24] ^ {7'h00, r[31:24] == FSR_OP_STATUS_READ}) : FSR_OP_STATUS_READ;
			nb = (n % 3 == 2) ? 1 + r[15:12] : 32;
			host.xfer(op, nb, got, goe);
			if (n % 3 == 1) chk("enable after wrong opcode", 0, goe | so_oe);
			else begin
				chk("status bytes", {e1, e2, e1, e2} >> (32 - nb), got);
				chk("enable in read", 32'hffffffff >> (32 - nb), goe);
				chk("enable after deselect", 0, so_oe);
			end
		end
		// Busy ends mid-read: every byte refreshes the ready flag
		@(posedge sys_clk) #1 lv = 7'h40;
		fork
			host.xfer(FSR_OP_STATUS_READ, 32, got, goe);
			#3000 lv = 7'h00;
		join
		chk("ready while polling", 2'b01, {got[31], got[7]});
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#2000000;
		miscompares++;
		test_done();
	end
endmodule
`default_nettype wire
